/* File: design/tpp_counter.sv */
// one 8-bit up counter with run control, tick input and clear request
`timescale 1ns/10ps
`default_nettype none
module tpp_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic tick,
  input wire logic clr,
  output logic [7:0] count
);
  import tpp_pkg::*;
  logic [7:0] count_r;
  logic [7:0] count_nxt;

  // a stopped counter sits at zero so restart begins cleanly
  always_comb begin
    count_nxt = count_r;
    if (!run) begin
      count_nxt = COUNT_RST;
    end else if (tick) begin
      count_nxt = clr ? COUNT_RST : 8'(count_r + 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
endmodule
`default_nettype wire

/* File: design/tpp_pkg.sv */
// package: mode codes, field positions and reset values of the timer pair
package tpp_pkg;
  localparam logic [1:0] MODE_TWO8 = 2'h0;
  localparam logic [1:0] MODE_CASC16 = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PER_HI = 5;
  localparam int PER_LO = 4;
  localparam int UCLK_HI = 3;
  localparam int UCLK_LO = 2;
  localparam int LCLK_HI = 1;
  localparam int LCLK_LO = 0;
  localparam logic [1:0] PER_6 = 2'h1;
  localparam logic [1:0] PER_7 = 2'h2;
  localparam logic [1:0] PER_8 = 2'h3;
  localparam logic [1:0] FFC_CLEAR = 2'h2;
  localparam logic [1:0] FFC_SET = 2'h1;
  localparam logic [1:0] FFC_INVERT = 2'h0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic FF_RST = 1'b0;
  localparam logic [7:0] PWM_TOP_6 = 8'h3f;
  localparam logic [7:0] PWM_TOP_7 = 8'h7f;
  localparam logic [7:0] PWM_TOP_8 = 8'hff;
endpackage

/* File: design/tpp_top.sv */
// timer pair with pulse, pwm and plain 8-bit timer output modes
`timescale 1ns/10ps
`default_nettype none
module tpp_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] MODE,
  input wire logic LOWER_RUN,
  input wire logic UPPER_RUN,
  input wire logic EXT_CLK_IN,
  input wire logic TAP_FINE,
  input wire logic TAP_MID,
  input wire logic TAP_COARSE,
  input wire logic TAP_SLOW,
  input wire logic [7:0] LOWER_CMP_WDATA,
  input wire logic LOWER_CMP_WE,
  input wire logic [7:0] UPPER_CMP_WDATA,
  input wire logic UPPER_CMP_WE,
  input wire logic [1:0] FF_CTRL_CODE,
  input wire logic FF_CTRL_WE,
  input wire logic TOGGLE_EN,
  input wire logic DBUF_EN,
  input wire logic FF_SRC_UPPER,
  output logic TIMER_OUT_PIN,
  output logic [7:0] LOWER_COUNT,
  output logic [7:0] UPPER_COUNT,
  output logic [7:0] LOWER_COMPARE,
  output logic LOWER_MATCH,
  output logic UPPER_MATCH
);
  import tpp_pkg::*;

  // external clock pin is asynchronous: two stages before use
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_tick;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= EXT_CLK_IN;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_tick = ext_s2_r & ~ext_s3_r;

  logic [1:0] mode;
  logic [1:0] per_sel;
  logic pulse_mode;
  logic pwm_mode;
  assign mode = MODE[MODE_HI:MODE_LO];
  assign per_sel = MODE[PER_HI:PER_LO];
  assign pulse_mode = (mode == MODE_PULSE);
  assign pwm_mode = (mode == MODE_PWM);

  logic [7:0] lcount;
  logic [7:0] ucount;
  logic [7:0] lcmp_r;
  logic [7:0] lcmp_nxt;
  logic [7:0] lbuf_r;
  logic [7:0] lbuf_nxt;
  logic [7:0] ucmp_r;
  logic [7:0] ucmp_nxt;
  logic ltick;
  logic utick;
  logic lmatch;
  logic umatch;
  logic pwm_ovf;
  logic [7:0] pwm_top;
  logic lclr;
  logic uclr;
  logic urun;
  logic lmatch_ev;
  logic [7:0] lnext;

  // lower counter clock: external, finest, mid or coarse tap
  always_comb begin
    unique case (MODE[LCLK_HI:LCLK_LO])
      2'h0: ltick = ext_tick;
      2'h1: ltick = TAP_FINE;
      2'h2: ltick = TAP_MID;
      2'h3: ltick = TAP_COARSE;
    endcase
  end

  // upper counter clock; lower match cascades only in split timer mode
  always_comb begin
    unique case (MODE[UCLK_HI:UCLK_LO])
      2'h0: utick = (mode == MODE_TWO8) ? lmatch_ev : 1'b0;
      2'h1: utick = TAP_FINE;
      2'h2: utick = TAP_COARSE;
      2'h3: utick = TAP_SLOW;
    endcase
  end

  // pwm top is 2^n-1 with n from the period field
  always_comb begin
    unique case (per_sel)
      PER_6: pwm_top = PWM_TOP_6;
      PER_7: pwm_top = PWM_TOP_7;
      PER_8: pwm_top = PWM_TOP_8;
      default: pwm_top = PWM_TOP_8;
    endcase
  end

  // compare against the value the count is about to reach, so a register of
  // n spans n ticks and the pwm period is 2^n-1 ticks rather than 2^n
  assign lnext = 8'(lcount + 8'h01);
  assign lmatch = (lnext == lcmp_r);
  assign umatch = (lnext == ucmp_r);
  assign lmatch_ev = ltick & lmatch;
  assign pwm_ovf = pwm_mode & ltick & (lnext == pwm_top);

  // lower counter clear: compare match in timer mode, period end otherwise
  always_comb begin
    if (pwm_mode) begin
      lclr = pwm_ovf;
    end else if (pulse_mode) begin
      lclr = umatch;
    end else begin
      lclr = lmatch;
    end
  end

  // upper counter is held at zero in pulse and cascade modes, free in pwm
  assign urun = UPPER_RUN & ~pulse_mode & (mode != MODE_CASC16);
  assign uclr = (8'(ucount + 8'h01) == ucmp_r);

  tpp_counter u_lower (
    .clk(CLK),
    .reset(RESET),
    .run(LOWER_RUN),
    .tick(ltick),
    .clr(lclr),
    .count(lcount)
  );

  tpp_counter u_upper (
    .clk(CLK),
    .reset(RESET),
    .run(urun),
    .tick(utick),
    .clr(uclr),
    .count(ucount)
  );

  // compare registers with double buffer on the lower one
  logic dbuf_load;
  assign dbuf_load = DBUF_EN & ((pulse_mode & ltick & umatch) | pwm_ovf);
  always_comb begin
    lbuf_nxt = LOWER_CMP_WE ? LOWER_CMP_WDATA : lbuf_r;
    ucmp_nxt = UPPER_CMP_WE ? UPPER_CMP_WDATA : ucmp_r;
    lcmp_nxt = lcmp_r;
    if (!DBUF_EN && LOWER_CMP_WE) begin
      lcmp_nxt = LOWER_CMP_WDATA;
    end else if (dbuf_load) begin
      lcmp_nxt = lbuf_r; // a write in the same cycle lands at the next load
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      lcmp_r <= CMP_RST;
      lbuf_r <= CMP_RST;
      ucmp_r <= CMP_RST;
    end else begin
      lcmp_r <= lcmp_nxt;
      lbuf_r <= lbuf_nxt;
      ucmp_r <= ucmp_nxt;
    end
  end

  // output flip-flop: software code first, then toggle events
  logic ff_r;
  logic ff_nxt;
  logic toggle_ev;
  always_comb begin
    if (pulse_mode) begin
      toggle_ev = ltick & LOWER_RUN & (lmatch | umatch);
    end else if (pwm_mode) begin
      toggle_ev = (lmatch_ev & LOWER_RUN) | pwm_ovf;
    end else if (mode == MODE_CASC16) begin
      toggle_ev = ltick & LOWER_RUN & lmatch & uclr;
    end else begin
      toggle_ev = FF_SRC_UPPER ? (utick & urun & uclr) : (lmatch_ev & LOWER_RUN);
    end
  end
  always_comb begin
    ff_nxt = ff_r;
    if (FF_CTRL_WE && FF_CTRL_CODE == FFC_CLEAR) begin
      ff_nxt = 1'b0;
    end else if (FF_CTRL_WE && FF_CTRL_CODE == FFC_SET) begin
      ff_nxt = 1'b1;
    end else if ((FF_CTRL_WE && FF_CTRL_CODE == FFC_INVERT) || (TOGGLE_EN && toggle_ev)) begin
      ff_nxt = ~ff_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ff_r <= FF_RST;
      LOWER_MATCH <= 1'b0;
      UPPER_MATCH <= 1'b0;
      LOWER_COUNT <= COUNT_RST;
      UPPER_COUNT <= COUNT_RST;
      LOWER_COMPARE <= CMP_RST;
    end else begin
      ff_r <= ff_nxt;
      LOWER_MATCH <= lmatch_ev & LOWER_RUN;
      UPPER_MATCH <= utick & urun & uclr;
      LOWER_COUNT <= lcount;
      UPPER_COUNT <= ucount;
      LOWER_COMPARE <= lcmp_r;
    end
  end
  assign TIMER_OUT_PIN = ff_r;

  property p_pwm_wrap;
    @(posedge CLK) disable iff (RESET) (pwm_ovf && LOWER_RUN) |=> (lcount == 8'h00);
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm counter did not wrap");
  property p_pwm_top_bound;
    @(posedge CLK) disable iff (RESET)
      (pwm_mode && $stable(MODE) && LOWER_RUN && $past(pwm_mode)) |-> (lcount < pwm_top);
  endproperty
  a_pwm_top_bound: assert property (p_pwm_top_bound) else $error("pwm count past top");
  property p_ff_toggle;
    @(posedge CLK) disable iff (RESET)
      (pulse_mode && TOGGLE_EN && toggle_ev && !FF_CTRL_WE) |=> (ff_r != $past(ff_r));
  endproperty
  a_ff_toggle: assert property (p_ff_toggle) else $error("output did not toggle");
  property p_ff_clear;
    @(posedge CLK) disable iff (RESET) (FF_CTRL_WE && FF_CTRL_CODE == FFC_CLEAR) |=> !ff_r;
  endproperty
  a_ff_clear: assert property (p_ff_clear) else $error("clear code failed");
  property p_ff_set;
    @(posedge CLK) disable iff (RESET) (FF_CTRL_WE && FF_CTRL_CODE == FFC_SET) |=> ff_r;
  endproperty
  a_ff_set: assert property (p_ff_set) else $error("set code failed");
  property p_stop_zero;
    @(posedge CLK) disable iff (RESET) !LOWER_RUN |=> (lcount == 8'h00);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("stopped counter not zero");
  property p_dbuf_pwm;
    @(posedge CLK) disable iff (RESET) (pwm_ovf && DBUF_EN) |=> (lcmp_r == $past(lbuf_r));
  endproperty
  a_dbuf_pwm: assert property (p_dbuf_pwm) else $error("no buffer load at overflow");
  property p_dbuf_pulse;
    @(posedge CLK) disable iff (RESET)
      (pulse_mode && ltick && umatch && DBUF_EN) |=> (lcmp_r == $past(lbuf_r));
  endproperty
  a_dbuf_pulse: assert property (p_dbuf_pulse) else $error("no load at period end");
  property p_pulse_restart;
    @(posedge CLK) disable iff (RESET)
      (pulse_mode && LOWER_RUN && ltick && umatch) |=> (lcount == 8'h00);
  endproperty
  a_pulse_restart: assert property (p_pulse_restart) else $error("no period restart");
  property p_upper_idle;
    @(posedge CLK) disable iff (RESET) pulse_mode ##1 pulse_mode |-> (ucount == 8'h00);
  endproperty
  a_upper_idle: assert property (p_upper_idle) else $error("upper counter moved");
  // with toggling off only a control write may move the output
  property p_toggle_gate;
    @(posedge CLK) disable iff (RESET) (!TOGGLE_EN && !FF_CTRL_WE) |=> $stable(ff_r);
  endproperty
  a_toggle_gate: assert property (p_toggle_gate) else $error("toggled while off");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench: drives the timer pair and checks pin waveforms and counters
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tpp_pkg::*;
  // clock starts at its low level so no false edge appears at time zero
  logic clk = 1'b0;
  logic reset, lrun, urun, fine, lwe, uwe, ffwe, tog, dbuf, pin, lm, um;
  logic [7:0] mode, lwd, uwd, lcnt, ucnt, lcmp, u0;
  logic [1:0] ffc;
  logic [8:0] hi_len, lo_len;
  int failures, samples_checked;
  int hits;

  // the four idle clock sources stay low; every pin test uses the fine tap
  tpp_top u_dut (.CLK(clk), .RESET(reset), .MODE(mode), .LOWER_RUN(lrun),
    .UPPER_RUN(urun), .EXT_CLK_IN(1'b0), .TAP_FINE(fine), .TAP_MID(1'b0),
    .TAP_COARSE(1'b0), .TAP_SLOW(1'b0), .LOWER_CMP_WDATA(lwd), .LOWER_CMP_WE(lwe),
    .UPPER_CMP_WDATA(uwd), .UPPER_CMP_WE(uwe), .FF_CTRL_CODE(ffc), .FF_CTRL_WE(ffwe),
    .TOGGLE_EN(tog), .DBUF_EN(dbuf), .FF_SRC_UPPER(1'b0), .TIMER_OUT_PIN(pin),
    .LOWER_COUNT(lcnt), .UPPER_COUNT(ucnt), .LOWER_COMPARE(lcmp),
    .LOWER_MATCH(lm), .UPPER_MATCH(um));
  tpp_pin_meter u_meter (.clk(clk), .pin(pin), .high_len(hi_len), .low_len(lo_len));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs only move at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // each strobe drops for a whole clock, so back-to-back calls never
  // lower and raise it in the same time step
  task automatic wr_lower(input logic [7:0] v);
    lwd = v;
    lwe = 1'b1;
    cyc(1);
    lwe = 1'b0;
    cyc(1);
  endtask
  task automatic wr_upper(input logic [7:0] v);
    uwd = v;
    uwe = 1'b1;
    cyc(1);
    uwe = 1'b0;
    cyc(1);
  endtask
  task automatic ff_write(input logic [1:0] c);
    ffc = c;
    ffwe = 1'b1;
    cyc(1);
    ffwe = 1'b0;
    cyc(1);
  endtask
  task automatic results();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 1750 clocks
  initial begin
    cyc(6000);
    failures++;
    results();
  end

  initial begin
    {lrun, urun, fine, lwe, uwe, ffwe, tog, dbuf} = 8'h00;
    reset = 1'b1; mode = MODE_RST; lwd = 8'h00; uwd = 8'h00; ffc = 2'h3;
    cyc(6);
    reset = 1'b0;
    cyc(1);
    chk({8'h00, pin}, 9'h000);
    ff_write(FFC_SET); chk({8'h00, pin}, 9'h001);
    ff_write(FFC_CLEAR); chk({8'h00, pin}, 9'h000);
    // pulse mode, lower compare kept below upper compare
    tog = 1'b1; fine = 1'b1;
    wr_lower(8'h02); wr_upper(8'h04);
    mode = {MODE_PULSE, 4'h0, 2'h1}; urun = 1'b1; lrun = 1'b1;
    cyc(20);
    // high spans upper minus lower compare, low spans the lower compare
    chk(hi_len, 9'h002);
    chk(lo_len, 9'h002);
    chk({1'b0, ucnt}, 9'h000);
    // halting holds the count at zero, so no buffer load can sneak in
    lrun = 1'b0; dbuf = 1'b1;
    cyc(3); chk({1'b0, lcnt}, 9'h000);
    wr_lower(8'h01); cyc(2); chk({1'b0, lcmp}, 9'h002);
    lrun = 1'b1;
    cyc(20); chk({1'b0, lcmp}, 9'h001);
    chk(hi_len, 9'h003);
    chk(lo_len, 9'h001);
    // pwm at period codes 1 to 3, compare below the overflow value
    for (int i = 0; i < 3; i++) begin
      lrun = 1'b0; dbuf = 1'b0;
      ff_write(FFC_CLEAR); wr_lower(8'h0a);
      mode = {MODE_PWM, 2'(i + 1), 2'h1, 2'h1}; lrun = 1'b1;
      // period is 2^n-1 ticks, so the window holds exactly three compare matches
      hits = 0;
      repeat (3 << (6 + i)) begin
        cyc(1);
        if (lm === 1'b1) hits++;
      end
      chk(9'(hits), 9'h003);
      chk(hi_len, (9'h001 << (6 + i)) - 9'h00b);
      chk(lo_len, 9'h00a);
      u0 = ucnt; cyc(1); chk({8'h00, ucnt !== u0}, 9'h001);
      // upper compare of four: two match pulses in any eight clocks
      hits = 0;
      repeat (8) begin
        cyc(1);
        if (um === 1'b1) hits++;
      end
      chk(9'(hits), 9'h002);
    end
    // buffered compare waits for the next overflow
    dbuf = 1'b1; wr_lower(8'h20);
    cyc(2); chk({1'b0, lcmp}, 9'h00a);
    cyc(300); chk({1'b0, lcmp}, 9'h020);
    results();
  end
endmodule
`default_nettype wire

/* File: verification/tpp_pin_meter.sv */
// partner model: outside circuit timing the levels it sees on the timer pin
`timescale 1ns/10ps
`default_nettype none
module tpp_pin_meter (
  input wire logic clk,
  input wire logic pin,
  output logic [8:0] high_len,
  output logic [8:0] low_len
);
  logic prev_r;
  logic [8:0] run_r;
  // each level length in clocks, latched when the pin next changes
  always_ff @(posedge clk) begin
    prev_r <= pin;
    if (pin !== prev_r) begin
      if (prev_r) high_len <= run_r;
      else low_len <= run_r;
      run_r <= 9'h001;
    end else begin
      run_r <= run_r + 9'h001;
    end
  end
endmodule
`default_nettype wire
